// file: logic/osac_top.sv
// Purpose: Oversampling control, averaging and result registers
// Assumes: samp_data and samp_valid come from the converter core on mclk
// Notes: Start and ratio pins are synchronised before use
`timescale 1ns/10ps
`include "osac_map.svh"

module osac_top #(
   parameter int NCH = 8,
   parameter int DW = 16
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic conversion_start_a,
   input wire logic conversion_start_b,
   input wire logic [2:0] ratio_select,
   input wire logic [NCH*DW-1:0] samp_data,
   input wire logic samp_valid,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic busy,
   output logic samp_req
);
   localparam int AW = DW + 6;
   localparam logic [6:0] SAMP_CYC = 7'(`OSAC_SAMP_CYC);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0] sel_meta_ff, sel_sync_ff;
   logic [1:0] cs_meta_ff, cs_sync_ff;
   logic cs_prev_ff;
   logic ctrl_en_ff;
   logic busy_ff, samp_req_ff;
   logic [2:0] ratio_cur_ff;
   logic [6:0] cnt_ff, gap_ff;
   logic [31:0] rdata_ff;
   osac_pkg::osac_state_e state_ff, nxt_state;
   logic signed [AW-1:0] acc_ff [NCH];
   logic signed [AW-1:0] nxt_acc [NCH];
   logic [DW-1:0] result_ff [NCH];
   logic [2:0] shift_n;
   logic [6:0] ratio_n, nxt_cnt;
   logic start_ok, last_samp, gap_done;
   logic hit_result, hit_status, hit_ctrl;
   logic [2:0] rd_ch;
   logic [31:0] rd_word;

   // Ratio code to shift amount, invalid treated as none
   function automatic logic [2:0] ratio_log2(input logic [2:0] code);
      if (code == `OSAC_RATIO_INVALID) begin
         return 3'h0;
      end
      return code;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sel_meta_ff <= 3'h0;
         sel_sync_ff <= 3'h0;
         cs_meta_ff <= 2'h0;
         cs_sync_ff <= 2'h0;
         cs_prev_ff <= 1'b0;
      end else begin
         sel_meta_ff <= ratio_select;
         sel_sync_ff <= sel_meta_ff;
         cs_meta_ff <= {conversion_start_b, conversion_start_a};
         cs_sync_ff <= cs_meta_ff;
         cs_prev_ff <= &cs_sync_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer decode
   assign shift_n = ratio_log2(ratio_cur_ff);
   assign ratio_n = 7'(1) << shift_n;
   assign start_ok = (&cs_sync_ff) && !cs_prev_ff && ctrl_en_ff
      && state_ff == osac_pkg::OSAC_IDLE;
   assign nxt_cnt = cnt_ff + 7'h01;
   assign last_samp = samp_valid && state_ff == osac_pkg::OSAC_WAIT
      && nxt_cnt == ratio_n;
   assign gap_done = state_ff == osac_pkg::OSAC_GAP && gap_ff == SAMP_CYC - 7'h01;

   // Accumulator next values
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         nxt_acc[i] = acc_ff[i] + AW'(signed'(samp_data[i*DW +: DW]));
      end
   end

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         osac_pkg::OSAC_IDLE: begin
            if (start_ok) begin
               nxt_state = osac_pkg::OSAC_WAIT;
            end
         end
         osac_pkg::OSAC_WAIT: begin
            if (last_samp) begin
               nxt_state = osac_pkg::OSAC_IDLE;
            end else if (samp_valid) begin
               nxt_state = osac_pkg::OSAC_GAP;
            end
         end
         osac_pkg::OSAC_GAP: begin
            if (gap_done) begin
               nxt_state = osac_pkg::OSAC_WAIT;
            end
         end
         default: begin
            nxt_state = osac_pkg::OSAC_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer, busy and sampling strobe
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_ff <= osac_pkg::OSAC_IDLE;
         busy_ff <= 1'b0;
         samp_req_ff <= 1'b0;
         cnt_ff <= 7'h00;
         gap_ff <= 7'h00;
         ratio_cur_ff <= `OSAC_RATIO_RESET;
      end else begin
         state_ff <= nxt_state;
         samp_req_ff <= start_ok || gap_done;
         gap_ff <= (state_ff == osac_pkg::OSAC_GAP) ? gap_ff + 7'h01 : 7'h00;
         if (start_ok) begin
            busy_ff <= 1'b1;
            cnt_ff <= 7'h00;
         end else if (last_samp) begin
            busy_ff <= 1'b0;
            cnt_ff <= nxt_cnt;
            ratio_cur_ff <= sel_sync_ff;
         end else if (samp_valid && state_ff == osac_pkg::OSAC_WAIT) begin
            cnt_ff <= nxt_cnt;
         end
      end
   end

   // Accumulators and output data registers
   always_ff @(posedge mclk) begin
      for (int i = 0; i < NCH; i++) begin
         if (sys_rst || start_ok) begin
            acc_ff[i] <= '0;
         end else if (samp_valid && state_ff == osac_pkg::OSAC_WAIT) begin
            acc_ff[i] <= nxt_acc[i];
         end
         if (sys_rst) begin
            result_ff[i] <= '0;
         end else if (last_samp) begin
            result_ff[i] <= DW'(nxt_acc[i] >>> shift_n);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register port decode
   assign hit_result = reg_addr < `OSAC_STATUS_OFS && reg_addr[1:0] == 2'h0
      && reg_addr[7:2] < 6'(NCH);
   assign hit_status = reg_addr == `OSAC_STATUS_OFS;
   assign hit_ctrl = reg_addr == `OSAC_CTRL_OFS;
   assign rd_ch = reg_addr[4:2];
   assign rd_word = hit_result ? {{(32-DW){1'b0}}, result_ff[rd_ch]}
      : hit_status ? {28'h0, ratio_cur_ff, busy_ff}
      : hit_ctrl ? {31'h0, ctrl_en_ff}
      : 32'h0;

   // Control write and read data
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_en_ff <= `OSAC_CTRL_RESET;
         rdata_ff <= 32'h0;
      end else begin
         if (reg_wr && hit_ctrl) begin
            ctrl_en_ff <= reg_wdata[`OSAC_CTRL_EN_BIT];
         end
         rdata_ff <= reg_rd ? rd_word : 32'h0;
      end
   end

   assign reg_rdata = rdata_ff;
   assign busy = busy_ff;
   assign samp_req = samp_req_ff;

   ////////////////////////////////////////////////////////////////////
   // Assertions
   a_busy_at_start: assert property (@(posedge mclk) disable iff (sys_rst)
      start_ok |=> busy_ff && samp_req_ff)
      else $error("busy or first sample missing after start");
   a_next_sample_gap: assert property (@(posedge mclk) disable iff (sys_rst)
      samp_valid && state_ff == osac_pkg::OSAC_WAIT && !last_samp
      |=> !samp_req_ff ##125 samp_req_ff)
      else $error("internal sample strobe mistimed");
   a_sample_count: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(busy_ff) |-> cnt_ff == (7'(1) << ratio_log2($past(ratio_cur_ff))))
      else $error("sample count does not match ratio");
   a_result_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
      !$fell(busy_ff) |-> $stable(result_ff[0]))
      else $error("result changed outside busy fall");
   a_result_held_busy: assert property (@(posedge mclk) disable iff (sys_rst)
      busy_ff && $past(busy_ff) |-> $stable(result_ff[NCH-1]))
      else $error("result changed while busy");
   a_ratio_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
      !$fell(busy_ff) |-> $stable(ratio_cur_ff))
      else $error("ratio changed outside busy fall");
   a_ratio_decode: assert property (@(posedge mclk) disable iff (sys_rst)
      (ratio_cur_ff == `OSAC_RATIO_INVALID |-> ratio_n == 7'h01)
      and (ratio_cur_ff == `OSAC_RATIO_MAX_CODE |-> ratio_n == 7'h40))
      else $error("ratio code decoded wrongly");
   a_no_os_passthru: assert property (@(posedge mclk) disable iff (sys_rst)
      last_samp && shift_n == 3'h0 |=> result_ff[0] == $past(samp_data[DW-1:0]))
      else $error("single sample result not passed through");
   c_plain_conv: cover property (@(posedge mclk) disable iff (sys_rst)
      $fell(busy_ff) && cnt_ff == 7'h01);
   c_os8_conv: cover property (@(posedge mclk) disable iff (sys_rst)
      $fell(busy_ff) && cnt_ff == 7'h08);
   c_read_busy: cover property (@(posedge mclk) disable iff (sys_rst)
      busy_ff && reg_rd && hit_result);
endmodule // osac_top

// file: logic/osac_map.svh
// Purpose: Constants for the oversampling and averaging control block
// Assumes: 25 MHz mclk, byte addresses on the register port
// Notes: Offsets, field positions, reset values and timing counts
//
// Contract
// - Busy lengthens as the ratio grows
// - Ratio code 000 none, 001-110 x2..x64, 111 invalid
// - Results load on busy falling edge
// - Earlier results readable while busy high
// - Averaging filter applied when oversampling
// - Ratio pins latched at busy fall, used next
// - First sample at start, rest internally timed
// - Averaged result reduced to 16 bits
`ifndef OSAC_MAP_SVH
`define OSAC_MAP_SVH

// Register offsets (byte addresses)
`define OSAC_RESULT_BASE 8'h00
`define OSAC_STATUS_OFS 8'h20
`define OSAC_CTRL_OFS 8'h24

// Field positions
`define OSAC_CTRL_EN_BIT 0
`define OSAC_STAT_BUSY_BIT 0
`define OSAC_STAT_RATIO_LSB 1

// Reset values
`define OSAC_CTRL_RESET 1'b1
`define OSAC_RATIO_RESET 3'h0

// Ratio codes
`define OSAC_RATIO_MAX_CODE 3'h6
`define OSAC_RATIO_INVALID 3'h7

// Internal sampling interval
`define OSAC_CLK_MHZ 25
`define OSAC_T_SAMP_NS 5000
`define OSAC_SAMP_CYC ((`OSAC_T_SAMP_NS * `OSAC_CLK_MHZ + 999) / 1000)

`endif

// file: logic/osac_pkg.sv
// Purpose: Types for the oversampling and averaging control block
// Assumes: Used by osac_top only
// Notes: Sequencer states
package osac_pkg;
   typedef enum logic [1:0] {
      OSAC_IDLE = 2'b00,
      OSAC_WAIT = 2'b01,
      OSAC_GAP = 2'b10
   } osac_state_e;
endpackage

// file: testbench/osac_core_model.sv
// Purpose: Converter core model answering sample requests
// Assumes: One sample set per request, latency set by bench
// Notes: Idle data lines toggle so stale values never match
`timescale 1ns/10ps
module osac_core_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic busy,
   input wire logic samp_req,
   input wire logic [3:0] lat,
   input wire logic [15:0] seed,
   output logic [127:0] samp_data,
   output logic samp_valid
);
   logic [3:0] cnt_ff;
   logic [7:0] n_ff;
   logic pend_ff;
   // One answer per request lat+1 cycles after it is seen, sample n of channel i
   always @(posedge mclk) begin
      samp_valid <= 1'b0;
      samp_data <= ~samp_data;
      if (!busy) n_ff <= 8'h00;
      if (sys_rst) begin
         pend_ff <= 1'b0;
         samp_data <= '0;
      end else if (samp_req) begin
         pend_ff <= 1'b1;
         cnt_ff <= lat;
      end else if (pend_ff && cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end else if (pend_ff) begin
         pend_ff <= 1'b0;
         samp_valid <= 1'b1;
         n_ff <= n_ff + 8'h01;
         for (int i = 0; i < 8; i++) samp_data[16*i+:16] <= seed + 16'(256*i) + 16'(3*n_ff);
      end
   end
endmodule // osac_core_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the oversampling control block
// Assumes: Both start pins driven from one signal
// Notes: Reads queue their expected word, a monitor compares
`timescale 1ns/10ps
module testbench;
   logic mclk, sys_rst, cs, rd, wr, busy, samp_req, samp_valid, rd_q, hung;
   logic [2:0] rsel, act;
   logic [127:0] sdata;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, lf;
   logic [3:0] lat;
   logic [15:0] seed;
   logic [15:0] exp_res [8];
   logic [31:0] exp_q [$];
   int err_total, comparisons, nreq, nbusy;
   osac_top dut (.mclk(mclk), .sys_rst(sys_rst), .conversion_start_a(cs),
      .conversion_start_b(cs), .ratio_select(rsel), .samp_data(sdata),
      .samp_valid(samp_valid), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata), .busy(busy), .samp_req(samp_req));
   osac_core_model core (.mclk(mclk), .sys_rst(sys_rst), .busy(busy), .samp_req(samp_req),
      .lat(lat), .seed(seed), .samp_data(sdata), .samp_valid(samp_valid));
   ////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task rd_reg(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk); // Idle cycle, strobe never drops and rises at once
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   // One conversion with new ratio pins, checks previous ratio's result
   task conv(input logic [2:0] code);
      int k, n, i;
      logic [23:0] s;
      if (hung) return;
      repeat (125) @(posedge mclk);
      #1;
      nreq = 0;
      nbusy = 0;
      lf = lfsr_next(lf);
      @(posedge mclk);
      seed <= {4'h0, lf[11:0]};
      lat <= lf[15:12] | 4'h4;
      rsel <= code;
      cs <= 1'b1;
      for (n = 0; n < 10 && !busy; n++) @(posedge mclk);
      cs <= 1'b0;
      rd_reg(8'h00, {16'h0, exp_res[0]});
      for (n = 0; n < 20000 && busy; n++) @(posedge mclk);
      if (busy) begin
         err_total++;
         hung = 1'b1;
         return;
      end
      k = (act == 3'h7) ? 0 : act;
      chk(nreq, 1 << k);
      chk(nbusy >= ((1 << k) - 1) * 125, 1);
      for (i = 0; i < 8; i++) begin
         s = '0;
         for (n = 0; n < (1 << k); n++) s += 24'(seed) + 24'(256 * i) + 24'(3 * n);
         exp_res[i] = 16'(s >> k);
         rd_reg(8'(4 * i), {16'h0, exp_res[i]});
      end
      rd_reg(8'h20, {28'h0, code, 1'b0});
      act = code;
   endtask
   ////////////////////////////////////////
   // Read monitor and activity counters
   always @(posedge mclk) begin
      rd_q <= rd;
      if (rd_q) chk(rdata, exp_q.pop_front());
      if (samp_req) nreq++;
      if (busy) nbusy++;
   end
   // Clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Main sequence
   initial begin
      {sys_rst, cs, rd, wr, hung} = 5'h10;
      {rsel, act, addr, wdata, seed, lat} = '0;
      lf = 32'h28696D09;
      foreach (exp_res[i]) exp_res[i] = 16'h0;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      rd_reg(8'h24, 32'h1);
      wr_reg(8'h20, 32'hF);
      rd_reg(8'h20, 32'h0);
      rd_reg(8'h30, 32'h0);
      for (int c = 0; c < 8; c++) conv(3'(c));
      conv(3'h1);
      wr_reg(8'h24, 32'h0);
      cs <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(busy, 1'b0);
      cs <= 1'b0;
      repeat (3) @(posedge mclk);
      tally_and_finish();
   end
endmodule // testbench
